/* frp_fault_response.sv */
// Overcurrent and internal overtemperature fault response policy
`timescale 1ns/1ps
`include "frp_cfg.svh"
module frp_fault_response
  import frp_pkg::*;
#(
  parameter int NUM_OUT   = 2,
  parameter int UNIT_CYC  = `FRP_UNIT_CYCLES,
  parameter int TIMER_W   = 16
)
(
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire frp_cmd_s                  cmd,
  input  wire logic                      clear_faults,
  input  wire logic                      restore_user,
  input  wire logic                      vendor_soft_reset_command,
  input  wire logic [TIMER_W-1:0]        restart_interval_setting,
  input  wire logic [NUM_OUT-1:0]        run_pin,
  input  wire logic [NUM_OUT-1:0]        operation_on,
  input  wire logic [NUM_OUT-1:0]        oc_detect,
  input  wire logic                      ot_detect,
  input  wire logic                      mask_oc,
  input  wire logic                      mask_ot,
  input  wire logic                      mask_comm,
  output logic [NUM_OUT-1:0]             out_enable_q,
  output frp_status_s [NUM_OUT-1:0]      status_q,
  output logic                           alert_n_q,
  output logic [7:0]                     rd_data_q,
  output logic                           rd_valid_q
);

  generate
    if (NUM_OUT < 1 || NUM_OUT > 2)
    begin : g_bad_out
      $error("frp_fault_response NUM_OUT must be 1 or 2");
    end
    if (UNIT_CYC < 2)
    begin : g_bad_unit
      $error("frp_fault_response UNIT_CYC must be at least 2");
    end
    if (TIMER_W < 3)
    begin : g_bad_timer
      $error("frp_fault_response TIMER_W must be at least 3");
    end
  endgenerate

  // Pins from outside the clock domain
  logic [NUM_OUT-1:0] run_s;
  logic [NUM_OUT-1:0] oc_s;
  logic               ot_s;

  frp_sync #(
    .WIDTH    (2*NUM_OUT+1)
  ) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({run_pin, oc_detect, ot_detect}),
    .sync_q   ({run_s, oc_s, ot_s})
  );

  // Free-running delay unit timebase
  logic [31:0] unit_cnt_q;
  logic [31:0] unit_cnt_d;
  logic        tick_q;
  wire  logic  unit_wrap = (unit_cnt_q == 32'(UNIT_CYC - 1));

  assign unit_cnt_d = unit_wrap ? 32'h0 : unit_cnt_q + 32'h1;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unit_cnt_q <= 32'h0;
      tick_q     <= 1'b0;
    end
    else
    begin
      unit_cnt_q <= unit_cnt_d;
      tick_q     <= unit_wrap;
    end
  end

  // Settings registers
  logic [7:0] oc_action_q [NUM_OUT];
  logic [7:0] internal_overtemp_action_q;

  wire logic       cmd_oc   = cmd.valid && (cmd.code == `FRP_CODE_OC_ACTION);
  wire logic       cmd_ot   = cmd.valid && (cmd.code == `FRP_CODE_OT_ACTION);
  wire logic [1:0] wr_resp  = cmd.data[`FRP_RESP_HI:`FRP_RESP_LO];
  wire logic       oc_wr_ok = cmd_oc && cmd.write && (wr_resp != `FRP_RESP_BAD);
  wire logic       oc_wr_bad = cmd_oc && cmd.write && (wr_resp == `FRP_RESP_BAD);
  wire logic       ot_wr_bad_code = (wr_resp == `FRP_RESP_CONTINUE)
                                 || (wr_resp == `FRP_RESP_BAD);
  wire logic       ot_wr_bad_retry =
                   (cmd.data[`FRP_RETRY_HI:`FRP_RETRY_LO] != `FRP_RETRY_NONE);
  // Register is read-only; any write attempt is refused as a comm fault
  wire logic       ot_wr_bad = cmd_ot && cmd.write
                            && (ot_wr_bad_code || ot_wr_bad_retry || 1'b1);
  wire logic       comm_err  = oc_wr_bad || ot_wr_bad;
  wire logic       page_ok   = (32'(cmd.page) < NUM_OUT);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      internal_overtemp_action_q <= `FRP_OT_ACTION_RESET;
    else
      internal_overtemp_action_q <= internal_overtemp_action_q;
  end

  // Read port; unknown codes answer zero
  wire logic [7:0] rd_mux = cmd_ot ? internal_overtemp_action_q
                          : (cmd_oc && page_ok) ? oc_action_q[cmd.page] : 8'h00;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_data_q  <= (cmd.valid && !cmd.write) ? rd_mux : rd_data_q;
      rd_valid_q <= cmd.valid && !cmd.write;
    end
  end

  // Internal overtemperature decode, delay field unused
  wire logic [1:0] ot_resp  = internal_overtemp_action_q[`FRP_RESP_HI:`FRP_RESP_LO];
  wire logic       ot_hold  = ot_s && (ot_resp == `FRP_RESP_IMMEDIATE);
  wire logic       ot_trip  = ot_s && (ot_resp == `FRP_RESP_DELAYED);

  // Device-wide sticky flags
  logic               ot_flag_q;
  logic               comm_flag_q;
  logic [NUM_OUT-1:0] run_rise;
  logic [NUM_OUT-1:0] oc_flag;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ot_flag_q   <= 1'b0;
      comm_flag_q <= 1'b0;
    end
    else
    begin
      // Set wins over a clear in the same cycle
      ot_flag_q   <= ot_s || (ot_flag_q && !clear_faults && !(|run_rise));
      comm_flag_q <= comm_err || (comm_flag_q && !clear_faults);
    end
  end

  // Per-output policy
  genvar i;
  generate
    for (i = 0; i < NUM_OUT; i++)
    begin : g_out
      frp_state_e         state_q;
      frp_state_e         state_d;
      logic [TIMER_W-1:0] timer_q;
      logic [TIMER_W-1:0] timer_d;
      logic               run_on_q;
      logic               oc_flag_q;

      wire logic       run_on   = run_s[i] && operation_on[i];
      wire logic [1:0] resp     = oc_action_q[i][`FRP_RESP_HI:`FRP_RESP_LO];
      wire logic [2:0] retry    = oc_action_q[i][`FRP_RETRY_HI:`FRP_RETRY_LO];
      wire logic [TIMER_W-1:0] dly =
                       TIMER_W'(oc_action_q[i][`FRP_DELAY_HI:`FRP_DELAY_LO]);
      wire logic       oc_now   = oc_s[i] && run_on;
      wire logic       oc_clear = clear_faults || restore_user
                               || vendor_soft_reset_command || run_rise[i];
      wire logic       wr_here  = oc_wr_ok && (32'(cmd.page) == i);
      // Retry 000 latches off; any other code restarts after the interval
      wire frp_state_e shut_st  = (retry == `FRP_RETRY_NONE) ? FRP_LATCHED
                                                             : FRP_RETRY_WAIT;
      wire logic       drive    = (state_q == FRP_ON || state_q == FRP_LIMIT)
                               && !ot_hold;

      assign run_rise[i] = run_on && !run_on_q;
      assign oc_flag[i]  = oc_flag_q;

      always_comb
      begin
        state_d = state_q;
        timer_d = timer_q;
        case (state_q)
          FRP_OFF:
            if (run_on)
              state_d = FRP_ON;
          FRP_ON:
            if (!run_on)
              state_d = FRP_OFF;
            else if (ot_trip)
              state_d = FRP_LATCHED;
            else if (oc_s[i] && resp == `FRP_RESP_DELAYED)
            begin
              state_d = FRP_LIMIT;
              timer_d = '0;
            end
            else if (oc_s[i] && resp == `FRP_RESP_IMMEDIATE)
            begin
              state_d = shut_st;
              timer_d = '0;
            end
            // Response 00 stays on: the analog limit holds the current
          FRP_LIMIT:
            if (!run_on)
              state_d = FRP_OFF;
            else if (ot_trip)
              state_d = FRP_LATCHED;
            else if (!oc_s[i] || resp != `FRP_RESP_DELAYED)
              state_d = FRP_ON;
            else if (tick_q)
            begin
              if (timer_q >= dly)
              begin
                state_d = shut_st;
                timer_d = '0;
              end
              else
                timer_d = timer_q + TIMER_W'(1);
            end
          FRP_RETRY_WAIT:
            if (!run_on)
              state_d = FRP_OFF;
            else if (ot_trip)
              state_d = FRP_LATCHED;
            else if (tick_q)
            begin
              if (timer_q >= restart_interval_setting)
                state_d = FRP_ON;
              else
                timer_d = timer_q + TIMER_W'(1);
            end
          FRP_LATCHED:
            if (!run_on)
              state_d = FRP_OFF;
          default:
            state_d = FRP_OFF;
        endcase
      end

      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          state_q        <= FRP_OFF;
          timer_q        <= '0;
          run_on_q       <= 1'b0;
          oc_flag_q      <= 1'b0;
          oc_action_q[i] <= `FRP_OC_ACTION_RESET;
          out_enable_q[i] <= 1'b0;
        end
        else
        begin
          state_q        <= state_d;
          timer_q        <= timer_d;
          run_on_q       <= run_on;
          oc_flag_q      <= oc_now || (oc_flag_q && !oc_clear);
          oc_action_q[i] <= wr_here ? cmd.data : oc_action_q[i];
          out_enable_q[i] <= drive;
        end
      end

      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          status_q[i] <= '0;
        else
        begin
          status_q[i].none_of_above   <= oc_flag_q || ot_flag_q;
          status_q[i].byte_iout_oc    <= oc_flag_q;
          status_q[i].word_iout       <= oc_flag_q;
          status_q[i].word_vendor     <= ot_flag_q;
          status_q[i].iout_oc_fault   <= oc_flag_q;
          status_q[i].vendor_ot_fault <= ot_flag_q;
          status_q[i].comm_fault      <= comm_flag_q;
        end
      end
    end
  endgenerate

  // Alert pin, low while any unmasked flag stands
  wire logic alert_src = ((|oc_flag) && !mask_oc)
                      || (ot_flag_q && !mask_ot)
                      || (comm_flag_q && !mask_comm);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      alert_n_q <= 1'b1;
    else
      alert_n_q <= !alert_src;
  end

endmodule

/* frp_cfg.svh */
// Constants for the fault response policy block
// Overview of operation
// - Any overcurrent sets its fault status bit and pulls alert unless masked.
// - Response 00 keeps the output running in current limit, never shutting down.
// - Response 10 limits for the delay, then applies retry if still limiting.
// - Response 11 disables the output at once, then applies retry.
// - Retry 000 keeps output off until run cycles off-on or power loss.
// - Retry 111 restarts endlessly, spaced by the restart interval, until off.
// - Delay field counts units of sixteen milliseconds.
// - Delay field matters only for the delayed shutdown response.
// - Overcurrent status stays set until clear, off-on, restore, vendor reset, power.
// - Overtemperature response is a read-only unpaged byte at 0xD6, default 0xC0.
// - Overtemperature sets none-of-above, word vendor and vendor status bits, alert.
// - Overtemperature response codes 00 and 01 raise a communication fault.
// - Overtemperature response 10 disables the output at once, then latches off whatever the retry field.
// - Overtemperature response 11 holds the output off only while hot.
// - Overtemperature retry other than 000 raises a communication fault.
// - Overtemperature delay field is ignored.
// - Overtemperature status latches until clear, off-on, or power cycle.
// - Overcurrent response is a read-write per-output byte at 0x47, default 0x00.
// - Overcurrent sets none-of-above, status byte, status word and current status bits.
`ifndef FRP_CFG_SVH
`define FRP_CFG_SVH

`define FRP_CODE_OC_ACTION   8'h47
`define FRP_CODE_OT_ACTION   8'hD6
`define FRP_OC_ACTION_RESET  8'h00
`define FRP_OT_ACTION_RESET  8'hC0

`define FRP_RESP_HI          7
`define FRP_RESP_LO          6
`define FRP_RETRY_HI         5
`define FRP_RETRY_LO         3
`define FRP_DELAY_HI         2
`define FRP_DELAY_LO         0

`define FRP_RESP_CONTINUE    2'h0
`define FRP_RESP_BAD         2'h1
`define FRP_RESP_DELAYED     2'h2
`define FRP_RESP_IMMEDIATE   2'h3
`define FRP_RETRY_NONE       3'h0

`define FRP_DELAY_UNIT_NS    16000000
`define FRP_CLK_PERIOD_NS    5
`define FRP_UNIT_CYCLES      (`FRP_DELAY_UNIT_NS / `FRP_CLK_PERIOD_NS)

`endif

/* frp_pkg.sv */
// Types shared by the fault response policy block
package frp_pkg;

  typedef enum logic [2:0] {
    FRP_OFF,
    FRP_ON,
    FRP_LIMIT,
    FRP_LATCHED,
    FRP_RETRY_WAIT
  } frp_state_e;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       page;
    logic [7:0] code;
    logic [7:0] data;
  } frp_cmd_s;

  typedef struct packed {
    logic none_of_above;
    logic byte_iout_oc;
    logic word_iout;
    logic word_vendor;
    logic iout_oc_fault;
    logic vendor_ot_fault;
    logic comm_fault;
  } frp_status_s;

endpackage

/* frp_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module frp_sync
  import frp_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_q
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;

  generate
    if (WIDTH < 1)
    begin : g_bad
      $error("frp_sync WIDTH must be at least 1");
    end
  endgenerate

  // First stage feeds only the second
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q   <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      stage2_q <= meta_q;
      stage3_q <= stage2_q;
    end
  end

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++)
    begin : g_bit
      // Change is taken only once two stages agree
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          sync_q[b] <= 1'b0;
        else if (stage2_q[b] == stage3_q[b])
          sync_q[b] <= stage3_q[b];
      end
    end
  endgenerate

endmodule

/* frp_fault_response_props.sv */
// Assertion checker for the fault response policy block
`timescale 1ns/1ps
module frp_fault_response_props
  import frp_pkg::*;
#(
  parameter int NUM_OUT = 2
)
(
  input wire logic               mclk,
  input wire logic               rst_n,
  input wire frp_cmd_s           cmd,
  input wire logic               clear_faults,
  input wire logic               restore_user,
  input wire logic               vendor_soft_reset_command,
  input wire logic [NUM_OUT-1:0] run_pin,
  input wire logic [NUM_OUT-1:0] operation_on,
  input wire logic               ot_detect,
  input wire logic               mask_oc,
  input wire logic               mask_ot,
  input wire logic [NUM_OUT-1:0] out_enable_q,
  input wire frp_status_s [NUM_OUT-1:0] status_q,
  input wire logic               alert_n_q,
  input wire logic [7:0]         rd_data_q,
  input wire logic               rd_valid_q
);
  logic [4:0] since_clr_q;
  logic [4:0] since_clr_d;
  wire        clr_evt;
  // Run is synchronised, so a clear may land a few cycles after its cause
  assign clr_evt = clear_faults | restore_user | vendor_soft_reset_command
                   | ~run_pin[0] | ~operation_on[0];
  assign since_clr_d = clr_evt ? 5'h00 : since_clr_q + {4'h0, ~&since_clr_q};
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      since_clr_q <= 5'h1F;
    else
      since_clr_q <= since_clr_d;
  end
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  ot_read_value_a : assert property (
    cmd.valid && !cmd.write && cmd.code == 8'hD6 |=> rd_valid_q && rd_data_q == 8'hC0)
    else $error("fixed action byte read wrong");
  ot_write_refused_a : assert property (
    cmd.valid && cmd.write && cmd.code == 8'hD6 && !clear_faults |-> ##3 status_q[0].comm_fault)
    else $error("fixed action byte write not flagged");
  oc_bad_code_a : assert property (
    cmd.valid && cmd.write && cmd.code == 8'h47 && cmd.data[7:6] == 2'b01 && !cmd.page
    && !clear_faults |-> ##3 status_q[0].comm_fault)
    else $error("bad response code not flagged");
  oc_summary_a : assert property (
    status_q[0].iout_oc_fault |-> status_q[0].none_of_above && status_q[0].byte_iout_oc
    && status_q[0].word_iout)
    else $error("overcurrent summary bits missing");
  ot_summary_a : assert property (
    status_q[0].vendor_ot_fault |-> status_q[0].none_of_above && status_q[0].word_vendor)
    else $error("overtemp summary bits missing");
  oc_alert_a : assert property (
    $rose(status_q[0].iout_oc_fault) && !mask_oc |=> !alert_n_q)
    else $error("overcurrent alert missing");
  ot_alert_a : assert property (
    $rose(status_q[0].vendor_ot_fault) && !mask_ot |=> !alert_n_q)
    else $error("overtemp alert missing");
  oc_sticky_a : assert property (
    $fell(status_q[0].iout_oc_fault) |-> since_clr_q < 5'd20)
    else $error("overcurrent flag dropped without cause");
  ot_hold_off_a : assert property (
    ot_detect [*8] |=> out_enable_q == '0)
    else $error("output on while hot");
  cover property (status_q[0].iout_oc_fault && out_enable_q[0]);
  cover property ($fell(out_enable_q[0]));
  cover property (status_q[0].iout_oc_fault && alert_n_q);
endmodule

bind frp_fault_response frp_fault_response_props #(
  .NUM_OUT                   (NUM_OUT)
) u_props (
  .mclk                      (mclk),
  .rst_n                     (rst_n),
  .cmd                       (cmd),
  .clear_faults              (clear_faults),
  .restore_user              (restore_user),
  .vendor_soft_reset_command (vendor_soft_reset_command),
  .run_pin                   (run_pin),
  .operation_on              (operation_on),
  .ot_detect                 (ot_detect),
  .mask_oc                   (mask_oc),
  .mask_ot                   (mask_ot),
  .out_enable_q              (out_enable_q),
  .status_q                  (status_q),
  .alert_n_q                 (alert_n_q),
  .rd_data_q                 (rd_data_q),
  .rd_valid_q                (rd_valid_q)
);

/* frp_host_model.sv */
// Host-side command model for the fault response policy block
`timescale 1ns/1ps
module frp_host_model
  import frp_pkg::*;
(
  input wire logic mclk,
  output frp_cmd_s cmd
);
  initial
    cmd = '0;
  // Released fields invert, so a stale byte never looks live
  task automatic access(input logic wr, input logic pg, input logic [7:0] code,
                        input logic [7:0] data);
    @(posedge mclk);
    #1;
    cmd = '{valid: 1'b1, write: wr, page: pg, code: code, data: data};
    @(posedge mclk);
    #1;
    cmd = '{valid: 1'b0, write: ~wr, page: ~pg, code: ~code, data: ~data};
  endtask
endmodule

/* tb_fault_response_policy.sv */
// Self-checking bench for the fault response policy block
`timescale 1ns/1ps
module tb_fault_response_policy
  import frp_pkg::*;
;
  localparam int         UNIT = 8;
  localparam logic [7:0] OT_WR [3] = '{8'h00, 8'h48, 8'h80};
  logic        mclk, rst_n, clear_faults, restore_user, vendor_soft_reset_command;
  logic        ot_detect, mask_oc, mask_ot, mask_comm, alert_n_q, rd_valid_q, p;
  logic [1:0]  run_pin, operation_on, oc_detect, out_enable_q;
  logic [15:0] restart_interval_setting;
  logic [7:0]  rd_data_q, v;
  logic [7:0]  exp_q[$];
  frp_cmd_s    cmd;
  frp_status_s [1:0] status_q;
  int          failures, check_count, cycles, seed;

  frp_fault_response #(.NUM_OUT(2), .UNIT_CYC(UNIT), .TIMER_W(16)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .cmd(cmd), .clear_faults(clear_faults),
    .restore_user(restore_user), .vendor_soft_reset_command(vendor_soft_reset_command),
    .restart_interval_setting(restart_interval_setting), .run_pin(run_pin),
    .operation_on(operation_on), .oc_detect(oc_detect), .ot_detect(ot_detect),
    .mask_oc(mask_oc), .mask_ot(mask_ot), .mask_comm(mask_comm),
    .out_enable_q(out_enable_q), .status_q(status_q), .alert_n_q(alert_n_q),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q));
  frp_host_model u_host (.mclk(mclk), .cmd(cmd));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic rd(input logic pg, input logic [7:0] code, input logic [7:0] exp);
    exp_q.push_back(exp);
    u_host.access(1'b0, pg, code, 8'h00);
  endtask

  task automatic pulse(input logic [2:0] k);
    {clear_faults, restore_user, vendor_soft_reset_command} = k;
    step(1);
    {clear_faults, restore_user, vendor_soft_reset_command} = 3'h0;
    step(4);
  endtask

  // Polls under a bound so a stuck output fails instead of hanging
  task automatic wait_en(input int i, input logic val, input int lim);
    int n;
    n = 0;
    while (out_enable_q[i] !== val && n < lim)
    begin
      step(1);
      n++;
    end
    check(out_enable_q[i], val);
  endtask

  always @(posedge mclk)
  begin
    #1;
    if (rd_valid_q === 1'b1)
      check(rd_data_q, exp_q.size() > 0 ? exp_q.pop_front() : ~rd_data_q);
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      results();
    end
  end

  initial
  begin
    seed = 86991;
    rst_n = 1'b0;
    {clear_faults, restore_user, vendor_soft_reset_command} = 3'h0;
    {ot_detect, mask_oc, mask_ot, mask_comm} = 4'h0;
    restart_interval_setting = 16'h0001;
    run_pin = 2'h3;
    operation_on = 2'h3;
    oc_detect = 2'h0;
    repeat (12) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    rd(1'b0, 8'hD6, 8'hC0);
    rd(1'b1, 8'h47, 8'h00);
    foreach (OT_WR[i])
      u_host.access(1'b1, 1'b0, 8'hD6, OT_WR[i]);
    u_host.access(1'b1, 1'b0, 8'h47, 8'h47);
    rd(1'b0, 8'hD6, 8'hC0);
    rd(1'b0, 8'h47, 8'h00);
    step(4);
    check(status_q[0].comm_fault, 1'b1);
    check(alert_n_q, 1'b0);
    pulse(3'h4);
    check(alert_n_q, 1'b1);
    repeat (4)
    begin
      v = 8'($random(seed));
      p = 1'($random(seed));
      if (v[7:6] == 2'b01)
        v[7] = 1'b1;
      u_host.access(1'b1, p, 8'h47, v);
      rd(p, 8'h47, v);
    end
    // Continue-in-limit with delay and retry set, both to be ignored
    u_host.access(1'b1, 1'b0, 8'h47, 8'h3F);
    oc_detect = 2'h1;
    step(60);
    check(out_enable_q[0], 1'b1);
    check(status_q[0], 8'h74);
    check(alert_n_q, 1'b0);
    oc_detect = 2'h0;
    step(20);
    check(status_q[0].iout_oc_fault, 1'b1);
    pulse(3'h2);
    check(status_q[0].iout_oc_fault, 1'b0);
    mask_oc = 1'b1;
    u_host.access(1'b1, 1'b0, 8'h47, 8'hC7);
    oc_detect = 2'h1;
    wait_en(0, 1'b0, 12);
    check(alert_n_q, 1'b1);
    oc_detect = 2'h0;
    step(100);
    check(out_enable_q[0], 1'b0);
    run_pin = 2'h2;
    step(10);
    run_pin = 2'h3;
    wait_en(0, 1'b1, 20);
    step(3);
    check(status_q[0].iout_oc_fault, 1'b0);
    mask_oc = 1'b0;
    u_host.access(1'b1, 1'b0, 8'h47, 8'hBA);
    oc_detect = 2'h1;
    // Third tick after entry cannot come before 17 cycles in limit
    step(20);
    check(out_enable_q[0], 1'b1);
    wait_en(0, 1'b0, 12);
    wait_en(0, 1'b1, 30);
    step(8);
    check(out_enable_q[0], 1'b1);
    oc_detect = 2'h0;
    wait_en(0, 1'b1, 40);
    // Let the synchronised fault drop first, else set wins over the clear
    step(6);
    pulse(3'h1);
    check(status_q[0].iout_oc_fault, 1'b0);
    ot_detect = 1'b1;
    wait_en(0, 1'b0, 12);
    step(4);
    check(out_enable_q, 2'h0);
    check(status_q[1], 8'h4A);
    check(alert_n_q, 1'b0);
    ot_detect = 1'b0;
    wait_en(0, 1'b1, 20);
    check(status_q[0].vendor_ot_fault, 1'b1);
    pulse(3'h4);
    check(status_q[0].vendor_ot_fault, 1'b0);
    check(8'(exp_q.size()), 8'h00);
    results();
  end
endmodule
